// ---- core/ecl_core.sv ----
/*
 * Command interpreter for event retrieval and the optional module list.
 * Request words are written over a plain register port, the command runs
 * once the whole request block is in, and the answer fills the response
 * words. Assumes the event feed, time and module map come from logic on
 * the same clock, and a master that keeps the request still while busy.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ecl_cfg.svh"
// How it works
// - newest, by date, or by sequence limit
// - at most ten events per command
// - device stamps rising sequence numbers
// - last sequence number readable in two words
// - zero password means none required
// - response echoes processed command code first
// - status zero success, nonzero error
// - response reports result byte count
// - selector echo zero, module count 0..14
// - module ids 1..13 and 15 only
// - module entries in consecutive words
// - event count high byte, more flag low
module ecl_core (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire ecl_pkg::ecl_bus_t bus_in,
   output logic [15:0] rdata_out,
   input wire ecl_pkg::ecl_evt_t evt_in,
   input wire logic [31:0] time_in,
   input wire logic [15:0] modules_in,
   output logic busy_out,
   output logic irq_out
);
   import ecl_pkg::*;
   // ==========================================================
   // declarations
   ecl_core_t s_q; // whole block state
   ecl_core_t s_d; // its next value
   ecl_entry_t scan_ent; // entry under the scan
   ecl_entry_t read_ent; // entry under a bus read
   logic [3:0] log_wp; // next ring slot
   logic [4:0] log_cnt; // entries held
   logic [31:0] log_seq; // newest sequence number
   logic log_new; // one cycle per logged event
   logic [3:0] scan_phys; // ring slot of scan age
   logic [3:0] pick; // ring slot of read event
   logic [15:0] poff; // field offset in read event
   logic [15:0] mo; // offset into module entries
   logic [15:0] rd_word; // read answer before register
   logic [15:0] req_err; // request check result
   logic ev_match; // scanned entry is selected
   logic mod_take; // scanned id is installed
   logic [9:0] ev_hit; // read address in event slot
   logic [9:0][15:0] ev_off; // offset into each slot
   logic fin; // command completes this cycle
   logic [15:0] fstat; // its status
   logic [2:0] iset; // interrupt events this cycle
   // ==========================================================
   // event log
   ecl_event_log ecl_event_log_inst (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .evt_in(evt_in),
      .time_in(time_in),
      .scan_idx_in(scan_phys),
      .read_idx_in(pick),
      .scan_ent_out(scan_ent),
      .read_ent_out(read_ent),
      .wp_out(log_wp),
      .cnt_out(log_cnt),
      .seq_out(log_seq),
      .logged_out(log_new)
   );
   // age zero is the newest entry
   assign scan_phys = 4'(log_wp - 4'h1 - s_q.scan[3:0]);
   // ==========================================================
   // request check, fixed order of tests
   always_comb
   begin
      req_err = `ECL_OK;
      if (s_q.cmd == `ECL_CMD_MOD)
      begin
         if (s_q.pcnt != `ECL_PCNT_MOD)
            req_err = `ECL_ERR_PCNT;
         else if (s_q.dest != `ECL_DEST_MOD)
            req_err = `ECL_ERR_DEST;
         else if (s_q.sec != `ECL_NONE)
            req_err = `ECL_ERR_SEC;
         else if (s_q.pw != {`ECL_NONE, `ECL_NONE})
            req_err = `ECL_ERR_PW;
         else if (s_q.sel != `ECL_SEL_ALL)
            req_err = `ECL_ERR_SEL;
      end
      else if (s_q.cmd == `ECL_CMD_EVT)
      begin
         if (s_q.pcnt != `ECL_PCNT_EVT)
            req_err = `ECL_ERR_PCNT;
         else if (s_q.pw != {`ECL_NONE, `ECL_NONE})
            req_err = `ECL_ERR_PW;
         else if (s_q.sel > `ECL_M_SEQ)
            req_err = `ECL_ERR_SEL;
      end
      else
      begin
         req_err = `ECL_ERR_CMD;
      end
   end
   // ==========================================================
   // selection of the scanned event
   always_comb
   begin
      ev_match = s_q.bookm[scan_ent.book] && s_q.sevm[scan_ent.sev];
      // limits include the boundary event itself
      if (s_q.sel == `ECL_M_DATE)
         ev_match = ev_match && (scan_ent.date <= s_q.lim);
      else if (s_q.sel == `ECL_M_SEQ)
         ev_match = ev_match && (scan_ent.seq <= s_q.lim);
   end
   // ids 0 and 14 are never reported
   assign mod_take = modules_in[s_q.scan[3:0]] && (s_q.scan[3:0] != `ECL_MOD_NONE);
   // ==========================================================
   // command engine, bus writes and interrupt flags
   always_comb
   begin
      s_d = s_q;
      fin = 1'b0;
      fstat = `ECL_OK;
      iset = 3'h0;
      s_d.fin = 1'b0;
      unique case (s_q.st)
         ECL_IDLE:
         begin
            // only a complete request block starts a command
            if (s_q.wmask == `ECL_REQ_ALL)
            begin
               s_d.wmask = '0;
               s_d.rcmd = `ECL_NONE;
               s_d.xcmd = s_q.cmd;
               s_d.kmod = (s_q.cmd == `ECL_CMD_MOD);
               s_d.mcnt = '0;
               s_d.ev_n = '0;
               s_d.more = 1'b0;
               s_d.scan = '0;
               if (req_err != `ECL_OK)
               begin
                  fin = 1'b1;
                  fstat = req_err;
               end
               else if (s_q.cmd == `ECL_CMD_MOD)
               begin
                  s_d.st = ECL_MODS;
                  s_d.scan = `ECL_MOD_FIRST;
               end
               else
               begin
                  s_d.st = ECL_EVTS;
               end
            end
         end
         ECL_MODS:
         begin
            // one id per cycle, packed with no gaps
            if (mod_take)
            begin
               s_d.mods[s_q.mcnt] = s_q.scan[3:0];
               s_d.mcnt = s_q.mcnt + 4'h1;
            end
            if (s_q.scan[3:0] == `ECL_MOD_LAST)
            begin
               fin = 1'b1;
            end
            s_d.scan = s_q.scan + 5'h01;
         end
         ECL_EVTS:
         begin
            // newest to oldest; an eleventh match only raises the flag
            if (s_q.scan >= log_cnt)
            begin
               fin = 1'b1;
            end
            else if (ev_match)
            begin
               if (s_q.ev_n == `ECL_EV_MAX)
               begin
                  s_d.more = 1'b1;
                  fin = 1'b1;
               end
               else
               begin
                  s_d.ev_idx[s_q.ev_n] = scan_phys;
                  s_d.ev_n = s_q.ev_n + 4'h1;
               end
            end
            s_d.scan = s_q.scan + 5'h01;
         end
         default:
         begin
            s_d.st = ECL_IDLE;
         end
      endcase
      // completion writes the code with status and byte count in one cycle, so the block reads as valid
      if (fin)
      begin
         s_d.st = ECL_IDLE;
         s_d.fin = 1'b1;
         s_d.rcmd = s_d.xcmd;
         s_d.rstat = fstat;
         if (fstat != `ECL_OK)
            s_d.rbytes = `ECL_NONE;
         else if (s_d.kmod)
            s_d.rbytes = `ECL_MOD_HDR_B + 16'(s_d.mcnt) * `ECL_MOD_B;
         else
            s_d.rbytes = `ECL_EV_HDR_B + 16'(s_d.ev_n) * `ECL_EV_B;
         iset[`ECL_IRQ_DONE] = 1'b1;
         iset[`ECL_IRQ_ERR] = (fstat != `ECL_OK);
      end
      iset[`ECL_IRQ_EVT] = log_new;
      // bus writes come after the engine so a new word is never lost
      if (bus_in.wr)
      begin
         case (bus_in.addr)
            `ECL_A_CMD: s_d.cmd = bus_in.wdata;
            `ECL_A_PCNT: s_d.pcnt = bus_in.wdata;
            `ECL_A_DEST: s_d.dest = bus_in.wdata;
            `ECL_A_SEC: s_d.sec = bus_in.wdata;
            `ECL_A_PWH: s_d.pw[31:16] = bus_in.wdata;
            `ECL_A_PWL: s_d.pw[15:0] = bus_in.wdata;
            `ECL_A_SEL: s_d.sel = bus_in.wdata;
            `ECL_A_BOOK: s_d.bookm = bus_in.wdata;
            `ECL_A_SEV: s_d.sevm = bus_in.wdata;
            `ECL_A_LIMH: s_d.lim[31:16] = bus_in.wdata;
            `ECL_A_LIML: s_d.lim[15:0] = bus_in.wdata;
            `ECL_A_IST: s_d.ist = s_q.ist & ~bus_in.wdata[2:0];
            `ECL_A_IMSK: s_d.imsk = bus_in.wdata[2:0];
            default:
            begin
            end
         endcase
         // track which words of the block have been written
         if ((bus_in.addr >= `ECL_A_CMD) && (bus_in.addr <= `ECL_A_SEL))
         begin
            s_d.wmask[3'(bus_in.addr - `ECL_A_CMD)] = 1'b1;
         end
      end
      // a set in the clearing cycle wins
      s_d.ist = s_d.ist | iset;
      s_d.rdata = bus_in.rd ? rd_word : 16'h0000;
   end
   // ==========================================================
   // state register
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   // ==========================================================
   // event slot address decode
   genvar g;
   generate
      for (g = 0; g < `ECL_EV_MAX; g++)
      begin : g_ev
         assign ev_off[g] = 16'(bus_in.addr - (`ECL_R_EV0 + 16'(g * `ECL_EV_WORDS)));
         assign ev_hit[g] = (ev_off[g] < `ECL_EV_WORDS) && (4'(g) < s_q.ev_n) && !s_q.kmod;
      end
   endgenerate
   // slot that the read falls in; at most one hits
   always_comb
   begin
      pick = '0;
      poff = '0;
      for (int i = 0; i < `ECL_EV_MAX; i++)
      begin
         if (ev_hit[i])
         begin
            pick = s_q.ev_idx[i];
            poff = ev_off[i];
         end
      end
   end
   // ==========================================================
   // read decode; unmapped words read zero
   always_comb
   begin
      rd_word = 16'h0000;
      mo = 16'(bus_in.addr - `ECL_R_MOD0);
      case (bus_in.addr)
         `ECL_A_CMD: rd_word = s_q.cmd;
         `ECL_A_PCNT: rd_word = s_q.pcnt;
         `ECL_A_DEST: rd_word = s_q.dest;
         `ECL_A_SEC: rd_word = s_q.sec;
         `ECL_A_PWH: rd_word = s_q.pw[31:16];
         `ECL_A_PWL: rd_word = s_q.pw[15:0];
         `ECL_A_SEL: rd_word = s_q.sel;
         `ECL_A_BOOK: rd_word = s_q.bookm;
         `ECL_A_SEV: rd_word = s_q.sevm;
         `ECL_A_LIMH: rd_word = s_q.lim[31:16];
         `ECL_A_LIML: rd_word = s_q.lim[15:0];
         `ECL_R_CMD: rd_word = s_q.rcmd;
         `ECL_R_STAT: rd_word = s_q.rstat;
         `ECL_R_BYTES: rd_word = s_q.rbytes;
         `ECL_A_LSQH: rd_word = log_seq[31:16];
         `ECL_A_LSQL: rd_word = log_seq[15:0];
         `ECL_A_IST: rd_word = {13'h0000, s_q.ist};
         `ECL_A_IMSK: rd_word = {13'h0000, s_q.imsk};
         default:
         begin
            // the answer area is laid out by the last command kind
            if (s_q.kmod)
            begin
               if (bus_in.addr == `ECL_R_SEL)
                  rd_word = `ECL_SEL_ALL;
               else if (bus_in.addr == `ECL_R_MCNT)
                  rd_word = {12'h000, s_q.mcnt};
               else if (mo < {12'h000, s_q.mcnt})
                  rd_word = {12'h000, s_q.mods[mo[3:0]]};
            end
            else if (bus_in.addr == `ECL_R_EVCNT)
            begin
               rd_word = {4'h0, s_q.ev_n, 7'h00, s_q.more};
            end
            else if (|ev_hit)
            begin
               case (poff)
                  `ECL_EVO_CODE: rd_word = read_ent.code;
                  `ECL_EVO_TSH: rd_word = read_ent.date[31:16];
                  `ECL_EVO_TSL: rd_word = read_ent.date[15:0];
                  `ECL_EVO_SQH: rd_word = read_ent.seq[31:16];
                  `ECL_EVO_SQL: rd_word = read_ent.seq[15:0];
                  `ECL_EVO_STS: rd_word = `ECL_STS_OCC;
                  `ECL_EVO_BOOK: rd_word = 16'h0001 << read_ent.book;
                  `ECL_EVO_SEV: rd_word = 16'h0001 << read_ent.sev;
                  default: rd_word = 16'h0000;
               endcase
            end
         end
      endcase
   end
   // ==========================================================
   // outputs, all from registers
   assign rdata_out = s_q.rdata;
   assign busy_out = (s_q.st != ECL_IDLE);
   assign irq_out = |(s_q.ist & s_q.imsk);
   // ==========================================================
   // checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   sequence s_mod_go;
      (s_q.st == ECL_IDLE) && (s_q.wmask == `ECL_REQ_ALL) && (s_q.cmd == `ECL_CMD_MOD)
      && (s_q.pw == {`ECL_NONE, `ECL_NONE}) && (req_err == `ECL_OK);
   endsequence
   sequence s_mod_run;
      (s_q.st == ECL_MODS) ##14 (s_q.st == ECL_MODS);
   endsequence
   a_mod_accept:
      assert property (s_mod_go |=> s_mod_run ##1 (s_q.fin && (s_q.rstat == `ECL_OK)))
      else $error("module list with zero password not accepted");
   a_echo_code:
      assert property (s_q.fin |-> (s_q.rcmd == s_q.xcmd) && (s_q.st == ECL_IDLE))
      else $error("response code does not echo the command");
   a_resp_hidden:
      assert property ((s_q.st != ECL_IDLE) |-> (s_q.rcmd == `ECL_NONE))
      else $error("response code visible while busy");
   a_bad_cmd:
      assert property (((s_q.st == ECL_IDLE) && (s_q.wmask == `ECL_REQ_ALL)
                       && (s_q.cmd != `ECL_CMD_MOD) && (s_q.cmd != `ECL_CMD_EVT))
                       |=> s_q.fin && (s_q.rstat == `ECL_ERR_CMD))
      else $error("unknown command not reported as error");
   a_ev_limit:
      assert property (s_q.ev_n <= `ECL_EV_MAX)
      else $error("more than ten events returned");
   a_more_full:
      assert property ($rose(s_q.more) |-> (s_q.ev_n == `ECL_EV_MAX) && s_q.fin)
      else $error("more flag set before ten events");
   a_mod_bytes:
      assert property ((s_q.fin && s_q.kmod && (s_q.rstat == `ECL_OK)) |->
                       (s_q.rbytes == `ECL_MOD_HDR_B + 16'(s_q.mcnt) * `ECL_MOD_B)
                       && (s_q.mcnt <= `ECL_MOD_MAX))
      else $error("module byte count wrong");
   a_mod_ids:
      assert property ((s_q.st == ECL_MODS) |-> (s_q.scan != '0))
      else $error("module id zero scanned");
   a_mod_order:
      assert property (((s_q.st == ECL_MODS) && mod_take) |=>
                       (s_q.mods[$past(s_q.mcnt)] == $past(s_q.scan[3:0]))
                       && (s_q.mcnt == $past(s_q.mcnt) + 4'h1))
      else $error("module entry not stored next");
   a_last_seq:
      assert property ((bus_in.rd && (bus_in.addr == `ECL_A_LSQL)) |=>
                       (rdata_out == $past(log_seq[15:0])))
      else $error("last sequence number read wrong");
endmodule
`default_nettype wire

// ---- inc/ecl_cfg.svh ----
/*
 * Constants of the event and module list command block: word addresses,
 * command codes, request checks, status codes and counts.
 * Assumes it is included once per file by its bare name.
 */
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH
// ==========================================================
// request block word addresses
`define ECL_A_CMD 16'h1F3F
`define ECL_A_PCNT 16'h1F40
`define ECL_A_DEST 16'h1F41
`define ECL_A_SEC 16'h1F42
`define ECL_A_PWH 16'h1F43
`define ECL_A_PWL 16'h1F44
`define ECL_A_SEL 16'h1F45
`define ECL_A_BOOK 16'h1F47
`define ECL_A_SEV 16'h1F48
`define ECL_A_LIMH 16'h1F49
`define ECL_A_LIML 16'h1F4A
// ==========================================================
// response block word addresses
`define ECL_R_CMD 16'h1F53
`define ECL_R_STAT 16'h1F54
`define ECL_R_BYTES 16'h1F55
`define ECL_R_SEL 16'h1F56
`define ECL_R_MCNT 16'h1F57
`define ECL_R_MOD0 16'h1F58
`define ECL_R_EVCNT 16'h1F5F
`define ECL_R_EV0 16'h1F60
// words per event and field offsets inside one event
`define ECL_EV_WORDS 16'h000B
`define ECL_EVO_CODE 16'h0000
`define ECL_EVO_TSH 16'h0001
`define ECL_EVO_TSL 16'h0002
`define ECL_EVO_SQH 16'h0006
`define ECL_EVO_SQL 16'h0007
`define ECL_EVO_STS 16'h0008
`define ECL_EVO_BOOK 16'h0009
`define ECL_EVO_SEV 16'h000A
// ==========================================================
// other registers
`define ECL_A_LSQH 16'h028E
`define ECL_A_LSQL 16'h028F
`define ECL_A_IST 16'h1FD0
`define ECL_A_IMSK 16'h1FD1
// ==========================================================
// commands, checks and codes
`define ECL_CMD_MOD 16'hC680
`define ECL_CMD_EVT 16'hC681
`define ECL_PCNT_MOD 16'h000C
`define ECL_PCNT_EVT 16'h0010
`define ECL_DEST_MOD 16'h1501
`define ECL_NONE 16'h0000
`define ECL_SEL_ALL 16'h0000
`define ECL_M_NEW 16'h0000
`define ECL_M_DATE 16'h0001
`define ECL_M_SEQ 16'h0002
`define ECL_OK 16'h0000
`define ECL_ERR_CMD 16'h0001
`define ECL_ERR_PCNT 16'h0002
`define ECL_ERR_DEST 16'h0003
`define ECL_ERR_SEC 16'h0004
`define ECL_ERR_PW 16'h0005
`define ECL_ERR_SEL 16'h0006
`define ECL_STS_OCC 16'h0100
// ==========================================================
// counts and byte figures
`define ECL_REQ_ALL 7'h7F
`define ECL_EV_MAX 4'hA
`define ECL_MOD_MAX 4'hE
`define ECL_MOD_FIRST 5'h01
`define ECL_MOD_NONE 4'hE
`define ECL_MOD_LAST 4'hF
`define ECL_MOD_HDR_B 16'h0004
`define ECL_MOD_B 16'h0002
`define ECL_EV_HDR_B 16'h0002
`define ECL_EV_B 16'h0016
`define ECL_LOG_FULL 5'h10
`define ECL_SEQ_STEP 32'h00000001
`define ECL_IRQ_DONE 0
`define ECL_IRQ_ERR 1
`define ECL_IRQ_EVT 2
`endif

// ---- inc/ecl_pkg.sv ----
/*
 * Types of the event and module list command block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ecl_pkg;
   // ==========================================================
   // carriers
   typedef enum logic [1:0] {ECL_IDLE, ECL_MODS, ECL_EVTS} ecl_state_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ecl_bus_t;
   typedef struct packed {
      logic valid;
      logic [15:0] code;
      logic [2:0] book;
      logic [3:0] sev;
   } ecl_evt_t;
   typedef struct packed {
      logic [15:0] code;
      logic [31:0] date;
      logic [31:0] seq;
      logic [2:0] book;
      logic [3:0] sev;
   } ecl_entry_t;
   // ==========================================================
   // module state
   typedef struct packed {
      ecl_entry_t [15:0] ent;
      logic [3:0] wp;
      logic [4:0] cnt;
      logic [31:0] seq;
      logic logged;
   } ecl_log_t;
   typedef struct packed {
      logic [15:0] cmd, pcnt, dest, sec, sel, bookm, sevm;
      logic [31:0] pw, lim;
      logic [6:0] wmask;
      ecl_state_t st;
      logic [4:0] scan;
      logic [15:0] xcmd, rcmd, rstat, rbytes, rdata;
      logic kmod;
      logic [3:0] mcnt;
      logic [13:0][3:0] mods;
      logic [3:0] ev_n;
      logic more;
      logic [9:0][3:0] ev_idx;
      logic fin;
      logic [2:0] ist, imsk;
   } ecl_core_t;
endpackage
`default_nettype wire

// ---- core/ecl_event_log.sv ----
/*
 * Event log ring: sixteen entries, each stamped with a sequence number.
 * Assumes events arrive from logic on the same clock, at most one a cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ecl_cfg.svh"
module ecl_event_log (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire ecl_pkg::ecl_evt_t evt_in,
   input wire logic [31:0] time_in,
   input wire logic [3:0] scan_idx_in,
   input wire logic [3:0] read_idx_in,
   output var ecl_pkg::ecl_entry_t scan_ent_out,
   output var ecl_pkg::ecl_entry_t read_ent_out,
   output logic [3:0] wp_out,
   output logic [4:0] cnt_out,
   output logic [31:0] seq_out,
   output logic logged_out
);
   import ecl_pkg::*;
   ecl_log_t s_q; // whole log state
   ecl_log_t s_d; // its next value
   // ==========================================================
   // logging: newest overwrites oldest once the ring is full
   always_comb
   begin
      s_d = s_q;
      s_d.logged = 1'b0;
      if (evt_in.valid)
      begin
         // numbers only ever grow, so order equals time order
         s_d.seq = s_q.seq + `ECL_SEQ_STEP;
         s_d.ent[s_q.wp] = '{code: evt_in.code, date: time_in, seq: s_d.seq,
                             book: evt_in.book, sev: evt_in.sev};
         s_d.wp = s_q.wp + 4'h1;
         if (s_q.cnt != `ECL_LOG_FULL)
         begin
            s_d.cnt = s_q.cnt + 5'h01;
         end
         s_d.logged = 1'b1;
      end
   end
   // ==========================================================
   // state register
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   // two independent read ports into the ring
   assign scan_ent_out = s_q.ent[scan_idx_in];
   assign read_ent_out = s_q.ent[read_idx_in];
   assign wp_out = s_q.wp;
   assign cnt_out = s_q.cnt;
   assign seq_out = s_q.seq;
   assign logged_out = s_q.logged;
   // ==========================================================
   // checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   a_seq_step:
      assert property (s_q.logged |-> s_q.seq == $past(s_q.seq) + `ECL_SEQ_STEP)
      else $error("sequence number did not step by one");
endmodule
`default_nettype wire

// ---- sim/ecl_master.sv ----
/*
 * Bus master model for the command block: register writes, reads, requests.
 * Assumes one clock; signals change just after rising edges.
 */
`timescale 1ns/100ps
`default_nettype none
module ecl_master (
   input wire logic clock_in,
   input wire logic [15:0] rdata_in,
   output var ecl_pkg::ecl_bus_t bus_out
);
   import ecl_pkg::*;
   // ==========================================================
   // bus cycles
   initial bus_out = '0;
   // one write strobe; a gap cycle follows, so no double drive
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock_in);
      bus_out <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_in);
      bus_out.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe; taken at its closing edge
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clock_in);
      bus_out <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clock_in);
      bus_out.rd <= 1'b0;
      @(posedge clock_in);
      d = rdata_in;
   endtask
   // ==========================================================
   // whole request block, security type always zero
   task automatic req(input logic [15:0] c, p, dst, pw, sel);
      wr(16'h1F3F, c);
      wr(16'h1F40, p);
      wr(16'h1F41, dst);
      wr(16'h1F42, 16'h0000);
      wr(16'h1F43, 16'h0000);
      wr(16'h1F44, pw);
      wr(16'h1F45, sel);
   endtask
endmodule
`default_nettype wire

// ---- sim/ecl_core_bench.sv ----
/*
 * Self-checking bench: module list, refused request, events, interrupts.
 * Assumes the master model drives the bus; events fed by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module ecl_core_bench;
   import ecl_pkg::*;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   ecl_bus_t bus;
   ecl_evt_t evt = '0;
   logic [31:0] tnow = 32'h00000000; // date fed beside each event
   logic [15:0] rdata, mods = 16'hC00B; // ids 0,1,3,14,15 set
   logic busy, irq;
   int failures = 0, check_count = 0, cyc = 0;
   always #4 clock_in = ~clock_in;
   ecl_core ecl_core_inst (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus),
      .rdata_out(rdata), .evt_in(evt), .time_in(tnow), .modules_in(mods),
      .busy_out(busy), .irq_out(irq));
   ecl_master ecl_master_inst (.clock_in(clock_in), .rdata_in(rdata), .bus_out(bus));
   // ==========================================================
   // compare helpers
   task automatic chk(input logic [15:0] g, e);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [15:0] a, e);
      logic [15:0] v;
      ecl_master_inst.rd(a, v);
      chk(v, e);
   endtask
   // bounded poll until the echo shows the code
   task automatic wait_cmd(input logic [15:0] c);
      logic [15:0] v;
      v = 16'h0000;
      for (int i = 0; i < 40 && v !== c; i++) ecl_master_inst.rd(16'h1F53, v);
      chk(v, c);
   endtask
   // one event pulse with its date; a quiet cycle follows
   task automatic log_evt(input logic [15:0] c, input logic [2:0] b, input logic [3:0] s,
                          input logic [31:0] d);
      @(posedge clock_in);
      evt <= '{1'b1, c, b, s};
      tnow <= d;
      @(posedge clock_in);
      evt <= '0;
   endtask
   task automatic print_verdict;
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // hang guard
   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         print_verdict();
      end
   end
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      rchk(16'h1F53, 16'h0000);
      rchk(16'h0000, 16'h0000); // unmapped
      ecl_master_inst.wr(16'h1FD1, 16'h0001);
      ecl_master_inst.req(16'hC680, 16'h000C, 16'h1501, 16'h0000, 16'h0000);
      wait_cmd(16'hC680);
      rchk(16'h1F53, 16'hC680);
      rchk(16'h1F54, 16'h0000);
      rchk(16'h1F55, 16'h000A);
      rchk(16'h1F56, 16'h0000);
      rchk(16'h1F57, 16'h0003);
      rchk(16'h1F58, 16'h0001);
      rchk(16'h1F59, 16'h0003);
      rchk(16'h1F5A, 16'h000F);
      chk({15'h0000, irq}, 16'h0001);
      ecl_master_inst.wr(16'h1FD0, 16'h0001);
      rchk(16'h1FD0, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      // refused: nonzero password
      ecl_master_inst.req(16'hC680, 16'h000C, 16'h1501, 16'h0001, 16'h0000);
      wait_cmd(16'hC680);
      rchk(16'h1F54, 16'h0005);
      rchk(16'h1F55, 16'h0000);
      // refused: unknown command code
      ecl_master_inst.req(16'h1234, 16'h000C, 16'h1501, 16'h0000, 16'h0000);
      wait_cmd(16'h1234);
      rchk(16'h1F54, 16'h0001);
      // two events, newest must come back first
      log_evt(16'h0101, 3'h1, 4'h8, 32'h00001000);
      log_evt(16'h0202, 3'h2, 4'h9, 32'h00002000);
      rchk(16'h028F, 16'h0002);
      ecl_master_inst.wr(16'h1F47, 16'h007F);
      ecl_master_inst.wr(16'h1F48, 16'hFFFF);
      ecl_master_inst.req(16'hC681, 16'h0010, 16'h0000, 16'h0000, 16'h0000);
      wait_cmd(16'hC681);
      rchk(16'h1F55, 16'h002E);
      rchk(16'h1F5F, 16'h0200);
      rchk(16'h1F60, 16'h0202);
      rchk(16'h1F67, 16'h0002);
      rchk(16'h1F69, 16'h0004);
      rchk(16'h1F72, 16'h0001);
      // nine more: only the newest ten come back, flag says more remain
      for (int i = 0; i < 9; i++)
      begin
         log_evt(16'h0300, 3'h3, 4'hA, 32'h00003000);
      end
      ecl_master_inst.req(16'hC681, 16'h0010, 16'h0000, 16'h0000, 16'h0000);
      wait_cmd(16'hC681);
      rchk(16'h1F55, 16'h00DE);
      rchk(16'h1F5F, 16'h0A01);
      rchk(16'h1F67, 16'h000B);
      rchk(16'h1FCA, 16'h0002);
      // by sequence limit 1: only the oldest one
      ecl_master_inst.wr(16'h1F4A, 16'h0001);
      ecl_master_inst.req(16'hC681, 16'h0010, 16'h0000, 16'h0000, 16'h0002);
      wait_cmd(16'hC681);
      rchk(16'h1F5F, 16'h0100);
      rchk(16'h1F60, 16'h0101);
      // by date limit, boundary included: only the oldest one
      ecl_master_inst.wr(16'h1F4A, 16'h1000);
      ecl_master_inst.req(16'hC681, 16'h0010, 16'h0000, 16'h0000, 16'h0001);
      wait_cmd(16'hC681);
      rchk(16'h1F5F, 16'h0100);
      rchk(16'h1F62, 16'h1000);
      print_verdict();
   end
endmodule
`default_nettype wire
